// File: rtl/asrs_sequencer.sv
// Sleep rail sequencer: state decode, rail enables, monitors, fault report
//
// Implementation choices: the Wishbone slave port and the register offsets.
`default_nettype none
module asrs_sequencer
  import asrs_pkg::*;
#(
  parameter int unsigned ACTIVE_WAIT = asrs_pkg::ACTIVE_WAIT_CYC,
  parameter int unsigned SLEEP_DELAY = asrs_pkg::SLEEP_DELAY_CYC,
  parameter int unsigned PG_DELAY    = asrs_pkg::PG_DELAY_CYC,
  parameter int unsigned DEGLITCH    = asrs_pkg::DEGLITCH_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Sleep requests and strap inputs (pins)
  input  wire logic        suspend_request_n_i,
  input  wire logic        soft_off_request_n_i,
  input  wire logic        keep_5v_in_soft_off_i,
  input  wire logic        lan_mode_i,
  input  wire logic        soft_start_low_i,
  // Supply and rail monitors (pins, high means above threshold)
  input  wire logic        main_3p3_supply_ok_i,
  input  wire logic        main_5v_supply_ok_i,
  input  wire logic        standby_3p3_rail_ok_i,
  input  wire logic        dual_5v_rail_ok_i,
  input  wire logic        lan_core_rail_ok_i,
  input  wire logic        id_1p2_rail_ok_i,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Rail drives
  output logic             standby_3p3_npn_drive_o,
  output logic             standby_3p3_switch_on_o,
  output logic             active_switch_gate_out_oe_o,
  output logic             standby_5v_switch_gate_o,
  output logic             id_1p2_rail_en_o,
  output logic             id_rail_good_n_oe_o,
  output logic             lan_rail_gate_drive_o,
  output logic             fault_o
);
  //////////////////////////////////////////////////////////////////////////
  // Input synchronisers and deglitch
  logic susp_n;
  logic soff_n;
  asrs_deglitch #(.FILT_CYC(DEGLITCH), .INIT(1'b1)) u_dg_susp (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (suspend_request_n_i),
    .filt_o (susp_n)
  );
  asrs_deglitch #(.FILT_CYC(DEGLITCH), .INIT(1'b1)) u_dg_soff (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .pin_i  (soft_off_request_n_i),
    .filt_o (soff_n)
  );

  logic [7:0] s1_ff;
  logic [7:0] s2_ff;
  // Standby, dual 5V and ID rail monitors read good until first sampled (LAN rail monitor resets low), so reset gives no false fault
  localparam logic [7:0] MON_SYNC_INIT = 8'h07;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_ff <= MON_SYNC_INIT;
      s2_ff <= MON_SYNC_INIT;
    end else begin
      s1_ff <= {keep_5v_in_soft_off_i, lan_mode_i, soft_start_low_i, main_3p3_supply_ok_i,
                main_5v_supply_ok_i, standby_3p3_rail_ok_i, dual_5v_rail_ok_i,
                id_1p2_rail_ok_i};
      s2_ff <= s1_ff;
    end
  end
  logic keep5;
  logic lan_keep;
  logic ss_low;
  logic m33_ok;
  logic m5_ok;
  logic sb33_ok;
  logic d5_ok;
  logic id_ok;
  logic lan_ok_s1_ff;
  logic lan_ok_ff;
  assign keep5    = s2_ff[7];
  assign lan_keep = s2_ff[6];
  assign ss_low   = s2_ff[5];
  assign m33_ok   = s2_ff[4];
  assign m5_ok    = s2_ff[3];
  assign sb33_ok  = s2_ff[2];
  assign d5_ok    = s2_ff[1];
  assign id_ok    = s2_ff[0];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lan_ok_s1_ff <= 1'b0;
      lan_ok_ff    <= 1'b0;
    end else begin
      lan_ok_s1_ff <= lan_core_rail_ok_i;
      lan_ok_ff    <= lan_ok_s1_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file
  logic [31:0] ctrl_ff;
  logic        ot_fault;
  logic        ot_shdn_ff;
  assign ot_fault = ctrl_ff[CTRL_OT_FAULT];

  //////////////////////////////////////////////////////////////////////////
  // Power state machine
  asrs_state_e state_ff;
  asrs_state_e nxt_state;
  logic [CNT_W-1:0] tmr_ff;
  logic [CNT_W-1:0] nxt_tmr;
  logic mains_ok;
  logic shut;
  logic is_active;
  logic in_s3;
  logic in_s5;
  assign mains_ok  = m33_ok & m5_ok;
  assign shut      = ss_low | ot_shdn_ff;
  assign is_active = (state_ff == ASRS_ACTIVE) | (state_ff == ASRS_DELAY);
  assign in_s3     = (state_ff == ASRS_S3);
  assign in_s5     = (state_ff == ASRS_S5) | (state_ff == ASRS_INIT);

  always_comb begin
    nxt_state = state_ff;
    nxt_tmr   = '0;
    unique case (state_ff)
      ASRS_INIT: begin
        // Bias up: standby rails start; pick active or sleep from requests
        if (susp_n && soff_n) begin
          nxt_state = ASRS_WAIT_ON;
        end else if (susp_n == 1'b0 && soff_n) begin
          nxt_state = ASRS_S3;
        end else if (!susp_n && !soff_n) begin
          nxt_state = ASRS_S5;
        end
      end
      ASRS_WAIT_ON: begin
        if (!(susp_n && soff_n) && !(!soff_n && susp_n)) begin
          nxt_state = soff_n ? ASRS_S3 : ASRS_S5;
        end else if (!mains_ok) begin
          nxt_tmr = '0;
        end else if (tmr_ff == CNT_W'(ACTIVE_WAIT - 1)) begin
          nxt_state = ASRS_ACTIVE;
        end else begin
          nxt_tmr = tmr_ff + CNT_W'(1);
        end
      end
      ASRS_ACTIVE: begin
        if (!mains_ok) begin
          nxt_state = ASRS_S5;
        end else if (!susp_n) begin
          nxt_state = ASRS_DELAY;
        end
      end
      ASRS_DELAY: begin
        if (!mains_ok) begin
          nxt_state = ASRS_S5;
        end else if (susp_n) begin
          nxt_state = ASRS_ACTIVE;
        end else if (tmr_ff == CNT_W'(SLEEP_DELAY - 1)) begin
          nxt_state = soff_n ? ASRS_S3 : ASRS_S5;
        end else begin
          nxt_tmr = tmr_ff + CNT_W'(1);
        end
      end
      ASRS_S3: begin
        if (susp_n && soff_n) begin
          nxt_state = ASRS_WAIT_ON;
        end else if (!susp_n && !soff_n) begin
          nxt_state = ASRS_S5;
        end
      end
      ASRS_S5: begin
        // S5 to S3 is blocked; only wake to active leaves this state
        if (susp_n && soff_n) begin
          nxt_state = ASRS_WAIT_ON;
        end
      end
      default: nxt_state = ASRS_INIT;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= ASRS_INIT;
      tmr_ff   <= '0;
    end else begin
      state_ff <= nxt_state;
      tmr_ff   <= nxt_tmr;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Rail enables
  logic id_latch_off_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_3p3_npn_drive_o     <= 1'b0;
      standby_3p3_switch_on_o     <= 1'b0;
      active_switch_gate_out_oe_o <= 1'b1;
      standby_5v_switch_gate_o    <= 1'b0;
      id_1p2_rail_en_o            <= 1'b0;
      lan_rail_gate_drive_o       <= 1'b0;
    end else if (shut) begin
      standby_3p3_npn_drive_o     <= 1'b0;
      standby_3p3_switch_on_o     <= 1'b0;
      active_switch_gate_out_oe_o <= 1'b1;
      standby_5v_switch_gate_o    <= 1'b0;
      id_1p2_rail_en_o            <= 1'b0;
      lan_rail_gate_drive_o       <= 1'b0;
    end else begin
      standby_3p3_npn_drive_o     <= !is_active;
      standby_3p3_switch_on_o     <= is_active;
      active_switch_gate_out_oe_o <= !is_active;
      standby_5v_switch_gate_o    <= in_s3 | (in_s5 & keep5);
      id_1p2_rail_en_o            <= is_active & !id_latch_off_ff;
      lan_rail_gate_drive_o       <= is_active | lan_keep;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // ID rail good delay and latch-off
  logic [CNT_W-1:0] pg_cnt_ff;
  logic             id_seen_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pg_cnt_ff           <= '0;
      id_rail_good_n_oe_o <= 1'b1;
    end else if (!id_1p2_rail_en_o || !id_ok) begin
      pg_cnt_ff           <= '0;
      id_rail_good_n_oe_o <= 1'b1;
    end else if (pg_cnt_ff == CNT_W'(PG_DELAY - 1)) begin
      id_rail_good_n_oe_o <= 1'b0;
    end else begin
      pg_cnt_ff <= pg_cnt_ff + CNT_W'(1);
    end
  end

  // Latch-off set wins over the soft-start clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      id_seen_ff      <= 1'b0;
      id_latch_off_ff <= 1'b0;
    end else begin
      if (ss_low) begin
        id_seen_ff      <= 1'b0;
        id_latch_off_ff <= 1'b0;
      end
      if (id_1p2_rail_en_o && id_ok) begin
        id_seen_ff <= 1'b1;
      end
      if (id_seen_ff && id_1p2_rail_en_o && !id_ok) begin
        id_latch_off_ff <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Fault report
  logic rail_uv;
  assign rail_uv = !sb33_ok | (!d5_ok & standby_5v_switch_gate_o)
                 | (!lan_ok_ff & lan_rail_gate_drive_o) | id_latch_off_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_o <= 1'b0;
    end else if (ss_low) begin
      fault_o <= 1'b0;
    end else begin
      fault_o <= rail_uv | (is_active & !mains_ok) | ot_fault | ot_shdn_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Wishbone slave
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff    <= CTRL_RESET;
      ot_shdn_ff <= 1'b0;
      wb_ack_o   <= 1'b0;
      wb_dat_o   <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & !wb_ack_o;
      if (ctrl_ff[CTRL_OT_SHDN]) begin
        ot_shdn_ff <= 1'b1;
      end
      if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
        if (wb_we_i && wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
          ctrl_ff[7:0] <= wb_dat_i[7:0];
        end
        unique case (wb_adr_i)
          REG_CTRL:   wb_dat_o <= ctrl_ff;
          REG_STATUS: wb_dat_o <= {16'h0000, 5'h00, state_ff, id_latch_off_ff,
                                   ot_shdn_ff, mains_ok, fault_o,
                                   id_rail_good_n_oe_o, id_1p2_rail_en_o,
                                   standby_5v_switch_gate_o, lan_rail_gate_drive_o};
          default:    wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Checks
  AST_SS_FAULT: assert property (@(posedge clk_i) disable iff (rst_i)
    ss_low |=> !fault_o) else $error("fault not cleared by soft-start low");
  AST_SS_SHUT: assert property (@(posedge clk_i) disable iff (rst_i)
    ss_low |=> !id_1p2_rail_en_o && !lan_rail_gate_drive_o && !standby_3p3_npn_drive_o)
    else $error("outputs not shut down");
  AST_ID_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
    id_1p2_rail_en_o |-> $past(is_active)) else $error("id regulator on in sleep");
  AST_GATE: assert property (@(posedge clk_i) disable iff (rst_i)
    !shut && $past(!shut) && is_active |=> !active_switch_gate_out_oe_o)
    else $error("active gate not released");
  AST_LOSS: assert property (@(posedge clk_i) disable iff (rst_i)
    is_active && !mains_ok |=> state_ff == ASRS_S5) else $error("no forced S5");
  AST_NO_S3: assert property (@(posedge clk_i) disable iff (rst_i)
    state_ff == ASRS_S5 |=> state_ff != ASRS_S3) else $error("S5 to S3 taken");
  AST_ENTRY: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state_ff == ASRS_ACTIVE) && $past(state_ff) == ASRS_WAIT_ON |-> $past(mains_ok))
    else $error("active without mains");
  AST_PG: assert property (@(posedge clk_i) disable iff (rst_i)
    !id_ok |=> id_rail_good_n_oe_o) else $error("good released below threshold");
  AST_LAN: assert property (@(posedge clk_i) disable iff (rst_i)
    !shut && (state_ff == ASRS_S3) && !lan_keep |=> !lan_rail_gate_drive_o)
    else $error("lan rail on in gigabit sleep");
  AST_ILLEGAL: assert property (@(posedge clk_i) disable iff (rst_i)
    susp_n && !soff_n && state_ff == ASRS_S3 |=> state_ff == ASRS_S3)
    else $error("illegal request changed state");
endmodule : asrs_sequencer
`default_nettype wire

// File: rtl/asrs_pkg.sv
// Package: constants and state types for the sleep rail sequencer
`default_nettype none
package asrs_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned DEGLITCH_NS     = 2_000;
  localparam int unsigned SLEEP_DELAY_NS  = 200_000;
  localparam int unsigned ACTIVE_WAIT_MS  = 50;
  localparam int unsigned PG_DELAY_US     = 1_000;
  localparam int unsigned DEGLITCH_CYC    = (CLK_HZ / 1_000_000) * DEGLITCH_NS / 1_000;
  localparam int unsigned SLEEP_DELAY_CYC = (CLK_HZ / 1_000_000) * SLEEP_DELAY_NS / 1_000;
  localparam int unsigned ACTIVE_WAIT_CYC = (CLK_HZ / 1_000) * ACTIVE_WAIT_MS;
  localparam int unsigned PG_DELAY_CYC    = (CLK_HZ / 1_000_000) * PG_DELAY_US;
  localparam int unsigned CNT_W           = 32;
  // Wishbone register offsets (byte addresses)
  localparam logic [3:0]  REG_CTRL   = 4'h0;
  localparam logic [3:0]  REG_STATUS = 4'h4;
  // Control register bit positions
  localparam int unsigned CTRL_OT_FAULT = 0;
  localparam int unsigned CTRL_OT_SHDN  = 1;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

  typedef enum logic [2:0] {
    ASRS_INIT    = 3'b000,
    ASRS_WAIT_ON = 3'b001,
    ASRS_ACTIVE  = 3'b011,
    ASRS_DELAY   = 3'b010,
    ASRS_S3      = 3'b110,
    ASRS_S5      = 3'b111
  } asrs_state_e;
endpackage : asrs_pkg
`default_nettype wire

// File: rtl/asrs_deglitch.sv
// Two-flop synchroniser followed by a stable-count deglitch filter
`default_nettype none
module asrs_deglitch #(
  parameter int unsigned FILT_CYC = 200,
  parameter logic        INIT     = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      filt_o
);
  logic        sync1_ff;
  logic        sync2_ff;
  logic [15:0] cnt_ff;
  localparam logic [15:0] FILT_LAST = 16'(FILT_CYC - 1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_ff <= INIT;
      sync2_ff <= INIT;
    end else begin
      sync1_ff <= pin_i;
      sync2_ff <= sync1_ff;
    end
  end

  // Output follows only after the input held its new level for the full window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= 16'h0000;
      filt_o <= INIT;
    end else if (sync2_ff == filt_o) begin
      cnt_ff <= 16'h0000;
    end else if (cnt_ff == FILT_LAST) begin
      cnt_ff <= 16'h0000;
      filt_o <= sync2_ff;
    end else begin
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule : asrs_deglitch
`default_nettype wire

// File: test/asrs_chipset_model.sv
// Chipset model: sleep request pins, short glitches and soft-start pull
`default_nettype none
module asrs_chipset_model (
  input  wire logic       clk_i,
  input  wire logic       susp_n_i,
  input  wire logic       soft_n_i,
  input  wire logic [2:0] glitch_i,
  input  wire logic       glitch_soft_i,
  input  wire logic       pull_ss_i,
  output logic            susp_n_o,
  output logic            soft_n_o,
  output logic            ss_low_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Glitch length counter and the line that it disturbs
  logic [2:0] gl_ff      = 3'h0;
  logic       gl_soft_ff = 1'b0;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (glitch_i != 3'h0) begin
      gl_ff      <= glitch_i;
      gl_soft_ff <= glitch_soft_i;
    end else if (gl_ff != 3'h0) begin
      gl_ff <= gl_ff - 3'h1;
    end
    susp_n_o <= susp_n_i ^ ((gl_ff != 3'h0) & !gl_soft_ff);
    soft_n_o <= soft_n_i ^ ((gl_ff != 3'h0) & gl_soft_ff);
    ss_low_o <= pull_ss_i;
  end
endmodule : asrs_chipset_model
`default_nettype wire

// File: test/asrs_sequencer_test.sv
// Testbench: sleep states, rail drives, faults and register access
`default_nettype none
module asrs_sequencer_test;
  import asrs_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, susp_n = 1'b0, soft_n = 1'b0;
  logic        pull_ss = 1'b0, keep = 1'b0, lan = 1'b0, m3 = 1'b0, m5 = 1'b0;
  logic        r_sb = 1'b1, r_d5 = 1'b1, r_lan = 1'b1, r_id = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, gsoft = 1'b0, r;
  logic [2:0]  glitch = 3'h0;
  logic [3:0]  adr = 4'h0;
  logic [3:0]  sel = 4'hf;
  logic [31:0] wdat = 32'h0, q;
  wire logic [31:0] rdat;
  wire logic   ack, npn, sw, oe, g5, iden, goe, lgate, fault, sp, so, ss;
  wire logic [6:0] rails = {npn, sw, oe, g5, iden, lgate, fault};
  int          fails = 0, total_checks = 0, cyc_cnt = 0, fault_hits = 0, hits0 = 0;
  asrs_chipset_model asrs_chipset_model_inst (.clk_i(clk_i), .susp_n_i(susp_n),
    .soft_n_i(soft_n), .glitch_i(glitch), .glitch_soft_i(gsoft),
    .pull_ss_i(pull_ss), .susp_n_o(sp),
    .soft_n_o(so), .ss_low_o(ss));
  asrs_sequencer #(.ACTIVE_WAIT(50), .SLEEP_DELAY(20), .PG_DELAY(10), .DEGLITCH(4))
  asrs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .suspend_request_n_i(sp),
    .soft_off_request_n_i(so), .keep_5v_in_soft_off_i(keep), .lan_mode_i(lan),
    .soft_start_low_i(ss), .main_3p3_supply_ok_i(m3), .main_5v_supply_ok_i(m5),
    .standby_3p3_rail_ok_i(r_sb), .dual_5v_rail_ok_i(r_d5),
    .lan_core_rail_ok_i(r_lan), .id_1p2_rail_ok_i(r_id), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .standby_3p3_npn_drive_o(npn),
    .standby_3p3_switch_on_o(sw), .active_switch_gate_out_oe_o(oe),
    .standby_5v_switch_gate_o(g5), .id_1p2_rail_en_o(iden),
    .id_rail_good_n_oe_o(goe), .lan_rail_gate_drive_o(lgate), .fault_o(fault));
  ////////////////////////////////////////////////////////////////////////
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (fault === 1'b1) begin
      fault_hits <= fault_hits + 1;
    end
    if (cyc_cnt == 30000) begin
      give_verdict(1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // A timeout enters as one extra mismatch
  task automatic give_verdict(input int extra);
    if (fails + extra == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s = 4'hf);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    sel  <= s;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc  <= 1'b0;
    stb  <= 1'b0;
  endtask : wb
  // Rails {npn, switch, gate oe, 5v gate, id en, lan, fault}; 0 active, 1 S3, 2 S5
  function automatic logic [6:0] exp_rails(input int st, input logic k, input logic l);
    if (st == 0) begin
      return 7'b0100110;
    end
    return {3'b101, (st == 1) | k, 1'b0, l, 1'b0};
  endfunction : exp_rails
  ////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(63159));
    tick(4);
    chk(rails, 7'b0010000);
    chk(goe, 1'b1);
    tick(1);
    rst_i <= 1'b0;
    tick(2);
    chk(fault, 1'b0);
    tick(38);
    chk(rails, exp_rails(2, keep, lan));
    susp_n <= 1'b1;
    soft_n <= 1'b1;
    m3     <= 1'b1;
    tick(100);
    chk(oe, 1'b1);
    m5 <= 1'b1;
    tick(30);
    chk(oe, 1'b1);
    while (iden !== 1'b1) @(posedge clk_i);
    tick(5);
    chk(goe, 1'b1);
    tick(25);
    chk(goe, 1'b0);
    chk(rails, exp_rails(0, keep, lan));
    for (int i = 0; i < 6; i++) begin
      keep   <= 1'($urandom);
      lan    <= 1'($urandom);
      gsoft  <= 1'($urandom);
      glitch <= 3'(1 + $urandom % 3);
      tick(1);
      glitch <= 3'h0;
      tick(40);
      chk(rails, exp_rails(0, keep, lan));
      soft_n <= 1'b0;
      tick(60);
      chk(rails, exp_rails(0, keep, lan));
      r = (i == 0) ? 1'b1 : 1'($urandom);
      susp_n <= 1'b0;
      soft_n <= r;
      tick(15);
      chk(rails, exp_rails(0, keep, lan));
      tick(40);
      chk(rails, exp_rails(r ? 1 : 2, keep, lan));
      gsoft  <= 1'b1;
      glitch <= 3'(1 + $urandom % 3);
      tick(1);
      glitch <= 3'h0;
      tick(20);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[10:8], r ? ASRS_S3 : ASRS_S5);
      soft_n <= 1'b0;
      tick(40);
      chk(rails, exp_rails(2, keep, lan));
      soft_n <= 1'b1;
      tick(40);
      chk(rails, exp_rails(2, keep, lan));
      wb(1'b0, REG_STATUS, 32'h0);
      chk(q[10:8], 3'h7);
      susp_n <= 1'b1;
      tick(100);
      chk(rails, exp_rails(0, keep, lan));
    end
    hits0 = fault_hits;
    m5 <= 1'b0;
    tick(40);
    chk(rails[6:4], 3'b101);
    chk(fault_hits != hits0, 1'b1);
    m5 <= 1'b1;
    tick(100);
    chk(rails, exp_rails(0, keep, lan));
    r_lan <= 1'b0;
    tick(10);
    chk(fault, 1'b1);
    r_lan <= 1'b1;
    tick(10);
    chk(rails, exp_rails(0, keep, lan));
    r_id <= 1'b0;
    tick(10);
    chk({iden, fault}, 2'b01);
    r_id <= 1'b1;
    tick(20);
    chk(iden, 1'b0);
    pull_ss <= 1'b1;
    tick(10);
    chk(rails, 7'b0010000);
    pull_ss <= 1'b0;
    tick(120);
    chk(rails, exp_rails(0, keep, lan));
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, CTRL_RESET);
    wb(1'b1, REG_CTRL, 32'h1, 4'he);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, CTRL_RESET);
    wb(1'b1, REG_CTRL, 32'h1);
    tick(5);
    chk(fault, 1'b1);
    wb(1'b1, 4'h8, 32'hff);
    wb(1'b0, 4'h8, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, 32'h1);
    wb(1'b1, REG_CTRL, 32'h0);
    tick(5);
    chk(fault, 1'b0);
    wb(1'b1, REG_CTRL, 32'h2);
    tick(5);
    chk(rails, 7'b0010001);
    rst_i <= 1'b1;
    tick(5);
    chk(rails, 7'b0010000);
    chk(goe, 1'b1);
    rst_i <= 1'b0;
    tick(2);
    chk(fault, 1'b0);
    tick(98);
    chk(rails, exp_rails(0, keep, lan));
    wb(1'b0, REG_CTRL, 32'h0);
    chk(q, CTRL_RESET);
    give_verdict(0);
  end
endmodule : asrs_sequencer_test
`default_nettype wire
